// ---- logic/emw_regs.vh ----
// Purpose: constants for the external memory wait and spurious read block
// Assumes: register file style access, byte wide
// Notes: definitions only
`ifndef EMW_REGS_VH
`define EMW_REGS_VH
`define EMW_WCR_ADDR 8'hfc
`define EMW_WCR_RESET 8'h7f
`define EMW_WCR_RSVD_BIT 7
`define EMW_WCR_TMODE_BIT 6
`define EMW_WCR_DW_HI 5
`define EMW_WCR_DW_LO 3
`define EMW_WCR_PW_HI 2
`define EMW_WCR_PW_LO 0
`define EMW_WAIT_W 3
`define EMW_ZERO_WAIT 3'h0
`define EMW_ONE 3'h1
// spurious operation codes
`define EMW_OP_NONE 4'h0
`define EMW_OP_DIV 4'h1
`define EMW_OP_MOVE 4'h2
`define EMW_OP_POP 4'h3
`define EMW_OP_USER_STACK_BYTE_PULL 4'h4
`define EMW_OP_SYSTEM_STACK_WORD_PULL 4'h5
`define EMW_OP_USER_STACK_WORD_PULL 4'h6
`define EMW_OP_RET 4'h7
`define EMW_OP_INTERRUPT_EXIT_INSTRUCTION 4'h8
`define EMW_OP_SLEEP 4'h9
`define EMW_OP_HALT 4'ha
`define EMW_OP_CALLI 4'hb
`define EMW_CNT_RET 2'h2
`define EMW_CNT_INTERRUPT_EXIT_INSTRUCTION 2'h3
`define EMW_CNT_SLEEP 2'h2
`define EMW_CNT_ONE 2'h1
`endif

// ---- logic/emw_wait_counter.v ----
// Purpose: counts wait cycles of one external bus access
// Assumes: tick is one internal base clock period
// Notes: loaded at access start, stretched while external wait is low
`timescale 1ns/1ns
`default_nettype none
`include "emw_regs.vh"
module emw_wait_counter (
  input wire core_clk,
  input wire reset,
  input wire clkEn,
  input wire load,
  input wire [`EMW_WAIT_W-1:0] loadValue,
  input wire waitLowSample,
  input wire waitSampleEn,
  output reg busy
);
  reg [`EMW_WAIT_W-1:0] remain;
  always @(posedge core_clk) begin
    if (reset) begin
      remain <= `EMW_ZERO_WAIT;
      busy <= 1'b0;
    end else if (clkEn) begin
      if (load) begin
        remain <= loadValue;
        busy <= 1'b1;
      end else if (busy) begin
        // external wait low adds a cycle and freezes the count
        if (waitSampleEn && waitLowSample) begin
          remain <= remain;
        end else if (remain != `EMW_ZERO_WAIT) begin
          remain <= remain - `EMW_ONE;
        end else begin
          busy <= 1'b0;
        end
      end
    end
  end
endmodule // emw_wait_counter
`default_nettype wire

// ---- logic/emw_ext_mem_ctrl.v ----
// Purpose: external bus cycles with programmed waits and spurious reads
// Assumes: core_clk ticks are internal base clock periods, 10 MHz
// Notes: one access in flight at a time; requests while busy are dropped
//
// Operation
// - divide refetches following code byte, program space
// - no refetch on divide overflow or zero trap
// - post-increment move reads destination before writing
// - internal byte pop reads data at stack pointer
// - word pop reads only for high byte
// - subroutine exit reads twice at system pointer
// - interrupt exit reads three times at system pointer
// - stack high bytes updated, software treats reserved
// - sleep instruction prefetches the following code byte twice
// - halt, indirect call prefetch one code byte
// - spurious reads look like normal bus cycles
// - wait control top bit reads zero
// - data wait field adds 0-7 cycles, reset 7
// - program wait field adds 0-7 cycles, reset 7
// - waits counted in internal base clock periods
// - clearing timer mode bit selects watchdog
// - wait input sampled low adds one cycle
// - on-chip memory accesses take no waits
`timescale 1ns/1ns
`default_nettype none
`include "emw_regs.vh"
module emw_ext_mem_ctrl (
  input wire core_clk,
  input wire reset,
  input wire clkEn,
  // register file port
  input wire regWr,
  input wire regRd,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  // core access request
  input wire accReq,
  input wire accWrite,
  input wire accProgram,
  input wire accOnChip,
  input wire [15:0] accAddr,
  input wire [7:0] accWdata,
  // spurious read event from the sequencer
  input wire [3:0] spurOp,
  input wire divOverflow,
  input wire divZeroTrap,
  input wire [15:0] codeAddr,
  input wire [15:0] destAddr,
  input wire destProgram,
  input wire [7:0] sysSpLow,
  input wire [7:0] userSpLow,
  input wire [7:0] sysSpHighIn,
  input wire [7:0] userSpHighIn,
  // external bus
  input wire waitEnable,
  input wire waitInLow,
  input wire [7:0] extRdata,
  output reg addressLatchStrobeLow,
  output reg dataPhaseStrobeLow,
  output reg readWriteLow,
  output reg programDataSel,
  output reg [15:0] extAddr,
  output reg [7:0] extWdata,
  output reg [7:0] extDataOutEnLow,
  // results
  output reg accDone,
  output reg [7:0] accRdata,
  output reg timerModeSelect,
  output reg [7:0] sysStackHigh,
  output reg [7:0] userStackHigh
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_ADDR = 4'b0010;
  localparam ST_WAIT = 4'b0100;
  localparam ST_END = 4'b1000;

  reg [3:0] state;
  reg [6:0] waitCtl;
  reg [1:0] spurLeft;
  reg [15:0] spurAddr;
  reg spurProg;
  reg curSpur;
  reg curWrite;
  reg pendMove;
  reg [15:0] moveAddr;
  reg [7:0] moveData;
  reg moveProg;
  reg loadWait;
  reg [`EMW_WAIT_W-1:0] waitValue;
  wire waitBusy;

  // full byte kept for the reset value; the reserved top bit has no storage
  localparam [7:0] WCR_RESET = `EMW_WCR_RESET;

  wire [`EMW_WAIT_W-1:0] dataWait = waitCtl[`EMW_WCR_DW_HI:`EMW_WCR_DW_LO];
  wire [`EMW_WAIT_W-1:0] progWait = waitCtl[`EMW_WCR_PW_HI:`EMW_WCR_PW_LO];
  wire wcrHit = (regAddr == `EMW_WCR_ADDR);

  // decoded register strobes
  // only one register lives here, so other addresses read back zero
  wire wcrWrite = regWr && wcrHit;
  wire wcrRead = regRd && wcrHit;
  wire otherRead = regRd && !wcrHit;

  // stored part of the wait control word, reserved bit dropped
  wire [6:0] wcrWriteValue = regWdata[`EMW_WCR_TMODE_BIT:0];

  // read image with the reserved bit forced low
  wire [7:0] wcrReadValue = {1'b0, waitCtl};

  // hazard: a wait field changed while a cycle is in flight
  // only affects the next access, the count is latched at start

  emw_wait_counter waitCount (
    .core_clk(core_clk),
    .reset(reset),
    .clkEn(clkEn),
    .load(loadWait),
    .loadValue(waitValue),
    .waitLowSample(waitInLow),
    .waitSampleEn(waitEnable),
    .busy(waitBusy)
  );

  // register file access
  always @(posedge core_clk) begin
    if (reset) begin
      waitCtl <= WCR_RESET[6:0];
      regRdata <= 8'h00;
      timerModeSelect <= WCR_RESET[`EMW_WCR_TMODE_BIT];
    end else if (clkEn) begin
      if (wcrWrite) begin
        waitCtl <= wcrWriteValue;
        timerModeSelect <= regWdata[`EMW_WCR_TMODE_BIT];
      end
      if (wcrRead) begin
        regRdata <= wcrReadValue;
      end else if (otherRead) begin
        regRdata <= 8'h00;
      end
    end
  end

  // spurious read scheduling
  always @(posedge core_clk) begin
    if (reset) begin
      spurLeft <= 2'h0;
      spurAddr <= 16'h0000;
      spurProg <= 1'b0;
      sysStackHigh <= 8'h00;
      userStackHigh <= 8'h00;
      pendMove <= 1'b0;
      moveAddr <= 16'h0000;
      moveData <= 8'h00;
      moveProg <= 1'b0;
    end else if (clkEn) begin
      if (state == ST_ADDR && curSpur && spurLeft != 2'h0)
        spurLeft <= spurLeft - `EMW_CNT_ONE;
      if (state == ST_ADDR && pendMove && curSpur && spurLeft == `EMW_CNT_ONE)
        pendMove <= 1'b1;
      else if (state == ST_ADDR && !curSpur)
        pendMove <= 1'b0;
      case (spurOp)
        `EMW_OP_DIV: begin
          if (!divOverflow && !divZeroTrap) begin
            spurLeft <= `EMW_CNT_ONE;
            spurAddr <= codeAddr;
            spurProg <= 1'b1;
          end
        end
        `EMW_OP_MOVE: begin
          spurLeft <= `EMW_CNT_ONE;
          spurAddr <= destAddr;
          spurProg <= destProgram;
          pendMove <= 1'b1;
          moveAddr <= destAddr;
          moveData <= accWdata;
          moveProg <= destProgram;
        end
        `EMW_OP_POP, `EMW_OP_SYSTEM_STACK_WORD_PULL, `EMW_OP_RET, `EMW_OP_INTERRUPT_EXIT_INSTRUCTION: begin
          // word pops read once, on the high byte only
          spurLeft <= (spurOp == `EMW_OP_RET) ? `EMW_CNT_RET :
                      (spurOp == `EMW_OP_INTERRUPT_EXIT_INSTRUCTION) ? `EMW_CNT_INTERRUPT_EXIT_INSTRUCTION :
                      `EMW_CNT_ONE;
          spurAddr <= {sysSpHighIn, sysSpLow};
          spurProg <= 1'b0;
          sysStackHigh <= sysSpHighIn;
        end
        `EMW_OP_USER_STACK_BYTE_PULL, `EMW_OP_USER_STACK_WORD_PULL: begin
          spurLeft <= `EMW_CNT_ONE;
          spurAddr <= {userSpHighIn, userSpLow};
          spurProg <= 1'b0;
          userStackHigh <= userSpHighIn;
        end
        `EMW_OP_SLEEP: begin
          spurLeft <= `EMW_CNT_SLEEP;
          spurAddr <= codeAddr;
          spurProg <= 1'b1;
        end
        `EMW_OP_HALT, `EMW_OP_CALLI: begin
          spurLeft <= `EMW_CNT_ONE;
          spurAddr <= codeAddr;
          spurProg <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // bus cycle sequencer
  always @(posedge core_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      curSpur <= 1'b0;
      curWrite <= 1'b0;
      loadWait <= 1'b0;
      waitValue <= `EMW_ZERO_WAIT;
      addressLatchStrobeLow <= 1'b1;
      dataPhaseStrobeLow <= 1'b1;
      readWriteLow <= 1'b1;
      programDataSel <= 1'b1;
      extAddr <= 16'h0000;
      extWdata <= 8'h00;
      extDataOutEnLow <= 8'hff;
      accDone <= 1'b0;
      accRdata <= 8'h00;
    end else if (clkEn) begin
      loadWait <= 1'b0;
      accDone <= 1'b0;
      case (state)
        ST_IDLE: begin
          // spurious reads go first, then the move's write, then core requests
          if (spurLeft != 2'h0) begin
            curSpur <= 1'b1;
            curWrite <= 1'b0;
            extAddr <= spurAddr;
            programDataSel <= spurProg;
            waitValue <= spurProg ? progWait : dataWait;
            addressLatchStrobeLow <= 1'b0;
            state <= ST_ADDR;
          end else if (pendMove) begin
            curSpur <= 1'b0;
            curWrite <= 1'b1;
            extAddr <= moveAddr;
            extWdata <= moveData;
            programDataSel <= moveProg;
            waitValue <= moveProg ? progWait : dataWait;
            addressLatchStrobeLow <= 1'b0;
            state <= ST_ADDR;
          end else if (accReq && accOnChip) begin
            accDone <= 1'b1;
          end else if (accReq) begin
            curSpur <= 1'b0;
            curWrite <= accWrite;
            extAddr <= accAddr;
            extWdata <= accWdata;
            programDataSel <= accProgram;
            waitValue <= accProgram ? progWait : dataWait;
            addressLatchStrobeLow <= 1'b0;
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          addressLatchStrobeLow <= 1'b1;
          dataPhaseStrobeLow <= 1'b0;
          readWriteLow <= ~curWrite;
          extDataOutEnLow <= curWrite ? 8'h00 : 8'hff;
          loadWait <= 1'b1;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (!loadWait && !waitBusy)
            state <= ST_END;
        end
        ST_END: begin
          dataPhaseStrobeLow <= 1'b1;
          readWriteLow <= 1'b1;
          extDataOutEnLow <= 8'hff;
          // spurious data is discarded
          if (!curSpur) begin
            accDone <= 1'b1;
            accRdata <= curWrite ? accRdata : extRdata;
          end
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // emw_ext_mem_ctrl
`default_nettype wire

// ---- test/emw_ext_mem_ctrl_assertions.sv ----
// Purpose: bus cycle checks on the external memory block
// Assumes: one clock, synchronous reset
// Notes: bound to the block's ports
`timescale 1ns/1ns
`default_nettype none
`include "emw_regs.vh"
module emw_ext_mem_ctrl_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic addressLatchStrobeLow,
  input wire logic dataPhaseStrobeLow,
  input wire logic programDataSel,
  input wire logic accDone,
  input wire logic timerModeSelect
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  rsvd_reads_zero_a: assert property ($past(regRd && clkEn) |-> regRdata[7] == 1'b0)
    else $error("reserved bit read as one");
  tmode_write_a: assert property (regWr && clkEn && regAddr == `EMW_WCR_ADDR
    |=> timerModeSelect == $past(regWdata[6])) else $error("timer mode bit not written");
  strobe_seq_a: assert property ($fell(addressLatchStrobeLow)
    |=> addressLatchStrobeLow && !dataPhaseStrobeLow) else $error("strobe order wrong");
  strobes_apart_a: assert property (!dataPhaseStrobeLow |-> addressLatchStrobeLow)
    else $error("both strobes low");
  pds_stable_a: assert property (!dataPhaseStrobeLow |-> $stable(programDataSel))
    else $error("space select moved in cycle");
  done_pulse_a: assert property (accDone |=> !accDone) else $error("done longer than one cycle");
  reset_idle_a: assert property ($past(reset) |-> addressLatchStrobeLow && dataPhaseStrobeLow
    && timerModeSelect) else $error("wrong state after reset");
  ds_bounded_a: assert property ($fell(dataPhaseStrobeLow) |-> ##[1:40] dataPhaseStrobeLow)
    else $error("data strobe stuck low");
  cover property (accDone);
  cover property ($fell(addressLatchStrobeLow) && programDataSel);
  cover property ($past(regRd) && regRdata != 8'h00);
endmodule // emw_ext_mem_ctrl_checker
bind emw_ext_mem_ctrl emw_ext_mem_ctrl_checker emw_ext_mem_ctrl_checker_inst (.*);
`default_nettype wire

// ---- test/emw_ext_mem_model.sv ----
// Purpose: external memory on the far side of the bus
// Assumes: byte memory, low address byte decoded
// Notes: slow asks for three wait samples per cycle
`timescale 1ns/1ns
`default_nettype none
module emw_ext_mem_model (
  input wire logic core_clk,
  input wire logic dataPhaseStrobeLow,
  input wire logic readWriteLow,
  input wire logic [15:0] extAddr,
  input wire logic [7:0] extWdata,
  input wire logic slow,
  output logic waitInLow,
  output logic [7:0] extRdata
);
  logic [7:0] mem [0:255];
  logic [7:0] last = 8'h00;
  int held = 0;
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0];
  always @(posedge core_clk) begin
    held <= dataPhaseStrobeLow ? 0 : held + 1;
    if (!dataPhaseStrobeLow && !readWriteLow) mem[extAddr[7:0]] <= extWdata;
    if (!dataPhaseStrobeLow) last <= mem[extAddr[7:0]];
  end
  // released bus shows inverted last byte so stale data never matches
  assign extRdata = (!dataPhaseStrobeLow && readWriteLow) ? mem[extAddr[7:0]] : ~last;
  assign waitInLow = slow && !dataPhaseStrobeLow && held < 3;
endmodule // emw_ext_mem_model
`default_nettype wire

// ---- test/emw_ext_mem_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the external memory block
// Assumes: 10 MHz clock, pulse requests
// Notes: timing judged by differences between wait settings
`timescale 1ns/1ns
`default_nettype none
`include "emw_regs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %0h want %0h", $time, a, b); end end
module emw_ext_mem_ctrl_tb_top;
  logic core_clk = 0, reset = 1, clkEn = 1, regWr = 0, regRd = 0, accReq = 0, accWrite = 0;
  logic accProgram = 0, accOnChip = 0, divOverflow = 0, divZeroTrap = 0, destProgram = 0;
  logic waitEnable = 0, slow = 0;
  logic [7:0] regAddr = 0, regWdata = 0, accWdata = 8'h12, sysSpLow = 8'h21, userSpLow = 8'h43;
  logic [7:0] sysSpHighIn = 8'h5a, userSpHighIn = 8'ha5;
  logic [15:0] accAddr = 16'h0812, codeAddr = 16'h1234, destAddr = 16'h0456;
  logic [3:0] spurOp = 0;
  logic waitInLow, addressLatchStrobeLow, dataPhaseStrobeLow, readWriteLow, programDataSel;
  logic accDone, timerModeSelect;
  logic [15:0] extAddr;
  logic [7:0] extRdata, regRdata, extWdata, extDataOutEnLow, accRdata, sysStackHigh, userStackHigh;
  int n_errors = 0, checks_done = 0, a, b, c, d, e, f;
  emw_ext_mem_ctrl emw_ext_mem_ctrl_inst (.*);
  emw_ext_mem_model emw_ext_mem_model_inst (.*);
  initial forever #50 core_clk = ~core_clk;
  task automatic step(int k = 1); repeat (k) @(posedge core_clk); endtask
  task automatic wr(input logic [7:0] ad, dt);
    step; regAddr <= ad; regWdata <= dt; regWr <= 1; step; regWr <= 0;
  endtask
  task automatic rd(input logic [7:0] ad, want);
    step; regAddr <= ad; regRd <= 1; step; regRd <= 0; #1 `CHK(regRdata, want)
  endtask
  task automatic acc(input logic p, oc, w, output int n);
    step; accProgram <= p; accOnChip <= oc; accWrite <= w; accReq <= 1;
    step; accReq <= 0; #1 n = 0;
    while (accDone !== 1'b1 && n < 200) begin step; #1 n++; end
    if (n >= 200) begin n_errors++; give_verdict; end
  endtask
  task automatic spur(input logic [3:0] op, input logic ov, zt, pds, input logic [7:0] lo,
      input int want);
    int cnt = 0;
    logic prev = 1;
    step; spurOp <= op; divOverflow <= ov; divZeroTrap <= zt; step; spurOp <= 4'h0;
    repeat (80) begin
      @(negedge core_clk);
      if (prev && !addressLatchStrobeLow) begin
        cnt++;
        `CHK(programDataSel, pds)
        `CHK(extAddr[7:0], lo)
      end
      prev = addressLatchStrobeLow;
    end
    `CHK(cnt, want)
  endtask
  task automatic t_regs;
    rd(8'hfc, 8'h7f);
    rd(8'h10, 8'h00);
    `CHK(timerModeSelect, 1'b1)
    wr(8'hfc, 8'hff); rd(8'hfc, 8'h7f);
    wr(8'hfc, 8'h00); rd(8'hfc, 8'h00);
    `CHK(timerModeSelect, 1'b0)
    $display("test regs done");
  endtask
  task automatic t_waits;
    wr(8'hfc, 8'h47); acc(1, 0, 0, a); acc(0, 0, 0, b);
    `CHK(accRdata, 8'h12)
    `CHK(a - b, 7)
    wr(8'hfc, 8'h78); acc(1, 0, 0, c); acc(0, 0, 1, d);
    `CHK(d - c, 7)
    `CHK(c, b)
    acc(0, 1, 0, e);
    `CHK(e < b, 1)
    step; waitEnable <= 1; slow <= 1; acc(1, 0, 0, f);
    `CHK(f > c, 1)
    step; waitEnable <= 0; slow <= 0;
    $display("test waits done");
  endtask
  task automatic t_spur;
    spur(`EMW_OP_DIV, 0, 0, 1'b1, 8'h34, 1);
    spur(`EMW_OP_DIV, 1, 0, 1'b1, 8'h34, 0);
    spur(`EMW_OP_DIV, 0, 1, 1'b1, 8'h34, 0);
    spur(`EMW_OP_MOVE, 0, 0, 1'b0, 8'h56, 2);
    spur(`EMW_OP_POP, 0, 0, 1'b0, 8'h21, 1);
    `CHK(sysStackHigh, 8'h5a)
    spur(`EMW_OP_USER_STACK_BYTE_PULL, 0, 0, 1'b0, 8'h43, 1);
    `CHK(userStackHigh, 8'ha5)
    spur(`EMW_OP_SYSTEM_STACK_WORD_PULL, 0, 0, 1'b0, 8'h21, 1);
    spur(`EMW_OP_USER_STACK_WORD_PULL, 0, 0, 1'b0, 8'h43, 1);
    spur(`EMW_OP_RET, 0, 0, 1'b0, 8'h21, 2);
    spur(`EMW_OP_INTERRUPT_EXIT_INSTRUCTION, 0, 0, 1'b0, 8'h21, 3);
    spur(`EMW_OP_SLEEP, 0, 0, 1'b1, 8'h34, 2);
    spur(`EMW_OP_HALT, 0, 0, 1'b1, 8'h34, 1);
    spur(`EMW_OP_CALLI, 0, 0, 1'b1, 8'h34, 1);
    $display("test spurious done");
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    step(3); reset <= 0;
    t_regs; t_waits; t_spur;
    give_verdict;
  end
endmodule // emw_ext_mem_ctrl_tb_top
`default_nettype wire
